// ---- temp_monitor_pkg.sv ----
// Constants, register map and state types for the temperature monitor control logic.
// Assumes a 10 MHz system clock and a host that masters the two-wire bus.
// Notes on behaviour
// - Device is bus slave only, never initiates.
// - Write byte: address, command, data, each acknowledged.
// - Read byte: command, repeated start, data, host NACKs.
// - Send byte loads pointer only, no register change.
// - Receive byte reads pointed register, pointer unchanged.
// - Wrong address or sequence: no ACK, registers untouched.
// - Never drive the clock line low.
// - 25 ms bus inactivity resets serial interface.
// - Power-up in standby: conversions halted, bus answers.
// - Run mode converts at rate, waits in low power.
// - One-shot in standby: one full set, back to standby.
// - Normal mode updates every channel each set.
// - Warmer mode stores greater remote into zone two.
// - Warmer mode flag shows which remote was hotter.
// - Equal remotes: flag cleared, each stored in own.
// - Conversion rates from 1 to 16 sets per second.
// - Averaging lengthens remote measurements 2x or 4x.
// - One-shot uses averaging of the selected rate.
// - Factor from max resolution, disable and rate limits.
package temp_monitor_pkg;
   localparam int CLK_HZ            = 10_000_000;
   localparam int TIMEOUT_MS        = 25;
   localparam int TIMEOUT_CYCLES    = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int SET_PERIOD_S      = 1;
   localparam int SET_PERIOD_CYCLES = SET_PERIOD_S * CLK_HZ;
   localparam int RESULT_W          = 11;
   localparam int PER_W             = 24;

   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_ONESHOT = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_ZONE0   = 8'h0C;
   localparam logic [7:0] OFS_ZONE1   = 8'h10;
   localparam logic [7:0] OFS_ZONE2   = 8'h14;
   localparam logic [7:0] OFS_LINK    = 8'h18;

   localparam logic [7:0] CMD_CONTROL   = 8'h00;
   localparam logic [7:0] CMD_ONESHOT   = 8'h01;
   localparam logic [7:0] CMD_STATUS    = 8'h02;
   localparam logic [7:0] CMD_ZONE_BASE = 8'h03;
   localparam logic [7:0] CMD_ZONE_LAST = 8'h08;

   localparam int CTL_STANDBY  = 0;
   localparam int CTL_WARMER   = 1;
   localparam int CTL_MAXRES   = 2;
   localparam int CTL_AVGDIS   = 3;
   localparam int CTL_RATE_LSB = 4;
   localparam int CTL_RATE_MSB = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h21;

   localparam logic [2:0] RATE_MAX    = 3'h4;
   localparam logic [2:0] RATE_4X_MAX = 3'h2;
   localparam logic [2:0] RATE_2X_MAX = 3'h3;

   localparam logic [1:0] AVG_1X = 2'h0;
   localparam logic [1:0] AVG_2X = 2'h1;
   localparam logic [1:0] AVG_4X = 2'h2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {SB_IDLE, SB_RX, SB_ACK, SB_TX, SB_TX_ACK} sbus_t;
   typedef enum logic [1:0] {SQ_SLEEP, SQ_WAIT, SQ_CONV, SQ_COMPARE} seq_t;
endpackage : temp_monitor_pkg

// ---- temp_monitor_smbus_sequencer.sv ----
// Two-wire bus slave, conversion sequencer and AXI4-Lite register slave.
// Assumes the converter front end shares clk_in; bus pins are asynchronous.
module temp_monitor_smbus_sequencer #(
   parameter int         TIMEOUT_CYCLES    = temp_monitor_pkg::TIMEOUT_CYCLES,
   parameter int         SET_PERIOD_CYCLES = temp_monitor_pkg::SET_PERIOD_CYCLES,
   parameter logic [6:0] SLAVE_ADDR        = 7'h2A  // Arbitrary default
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        serial_bus_clock_pin_in,
   input  wire logic        serial_bus_data_pin_in,
   output logic             serial_bus_data_pin_out,
   output logic             serial_bus_data_pin_oe_out,
   output logic             adc_start_out,
   output logic [1:0]       adc_channel_out,
   output logic [1:0]       adc_average_out,
   input  wire logic        adc_done_in,
   input  wire logic [10:0] adc_result_in,
   output logic             low_power_out,
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in
);
   localparam int TO_W = $clog2(TIMEOUT_CYCLES);
   localparam int RW   = temp_monitor_pkg::RESULT_W;
   localparam int PW   = temp_monitor_pkg::PER_W;

   // Pin synchronisers, reset to the idle-high bus level
   logic [1:0] scl_s_reg;
   logic [1:0] sda_s_reg;
   logic       scl_d_reg;
   logic       sda_d_reg;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         scl_s_reg <= 2'h3;
         sda_s_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_s_reg <= {scl_s_reg[0], serial_bus_clock_pin_in};
         sda_s_reg <= {sda_s_reg[0], serial_bus_data_pin_in};
         scl_d_reg <= scl_s_reg[1];
         sda_d_reg <= sda_s_reg[1];
      end
   end

   wire scl       = scl_s_reg[1];
   wire sda       = sda_s_reg[1];
   wire scl_rise  = scl & ~scl_d_reg;
   wire scl_fall  = ~scl & scl_d_reg;
   wire start_det = scl & scl_d_reg & ~sda & sda_d_reg;
   wire stop_det  = scl & scl_d_reg & sda & ~sda_d_reg;
   wire any_edge  = (scl ^ scl_d_reg) | (sda ^ sda_d_reg);

   // Inactivity timer, saturates so the slave stays parked
   logic [TO_W-1:0] to_cnt_reg;
   wire             to_hit = (to_cnt_reg == TO_W'(TIMEOUT_CYCLES - 1));

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         to_cnt_reg <= '0;
      else if (any_edge)
         to_cnt_reg <= '0;
      else if (!to_hit)
         to_cnt_reg <= to_cnt_reg + TO_W'(1);
   end

   // Slave byte engine
   temp_monitor_pkg::sbus_t sb_state_reg;
   logic [7:0] sb_shift_reg;
   logic [3:0] sb_bits_reg;
   logic [1:0] sb_byte_reg;
   logic       sb_read_reg;
   logic       sb_oe_reg;
   logic [7:0] pointer_reg;
   logic [7:0] ctl_reg;
   logic [RW-1:0] res_reg [3];
   logic       hotter_reg;
   logic       os_pend_reg;
   logic       busy;

   wire byte_done = (sb_state_reg == temp_monitor_pkg::SB_RX) & scl_fall & (sb_bits_reg == 4'h8);
   wire addr_hit  = (sb_shift_reg[7:1] == SLAVE_ADDR);
   wire writable  = (pointer_reg == temp_monitor_pkg::CMD_CONTROL) |
                    (pointer_reg == temp_monitor_pkg::CMD_ONESHOT);
   wire ack_now   = (sb_byte_reg == 2'h0) ? addr_hit :
                    (sb_byte_reg == 2'h1) ? 1'b1 :
                    (sb_byte_reg == 2'h2) ? writable : 1'b0;
   wire ptr_load  = byte_done & (sb_byte_reg == 2'h1);
   wire smb_wr    = byte_done & (sb_byte_reg == 2'h2) & writable;
   wire smb_ctl_wr = smb_wr & (pointer_reg == temp_monitor_pkg::CMD_CONTROL);
   wire smb_os_wr  = smb_wr & (pointer_reg == temp_monitor_pkg::CMD_ONESHOT);

   // Read byte selection from the pointer
   wire [7:0]    zi      = pointer_reg - temp_monitor_pkg::CMD_ZONE_BASE;
   wire [1:0]    zidx    = (zi[2:1] == 2'h3) ? 2'h2 : zi[2:1];
   wire          is_zone = (pointer_reg >= temp_monitor_pkg::CMD_ZONE_BASE) &
                           (pointer_reg <= temp_monitor_pkg::CMD_ZONE_LAST);
   wire [RW-1:0] zval    = res_reg[zidx];
   wire [7:0]    zbyte   = zi[0] ? {zval[2:0], 5'h00} : zval[RW-1:3];
   wire [7:0]    status  = {5'h00, os_pend_reg, busy, hotter_reg};
   wire [7:0]    rd_byte = is_zone ? zbyte :
                           (pointer_reg == temp_monitor_pkg::CMD_CONTROL) ? ctl_reg :
                           (pointer_reg == temp_monitor_pkg::CMD_STATUS) ? status : 8'h00;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sb_state_reg <= temp_monitor_pkg::SB_IDLE;
         sb_shift_reg <= 8'h00;
         sb_bits_reg  <= 4'h0;
         sb_byte_reg  <= 2'h0;
         sb_read_reg  <= 1'b0;
         sb_oe_reg    <= 1'b0;
      end else if (start_det) begin
         sb_state_reg <= temp_monitor_pkg::SB_RX;
         sb_bits_reg  <= 4'h0;
         sb_byte_reg  <= 2'h0;
         sb_oe_reg    <= 1'b0;
      end else if (stop_det || to_hit) begin
         sb_state_reg <= temp_monitor_pkg::SB_IDLE;
         sb_oe_reg    <= 1'b0;
      end else begin
         unique case (sb_state_reg)
            temp_monitor_pkg::SB_IDLE: begin
            end
            temp_monitor_pkg::SB_RX: begin
               if (scl_rise && sb_bits_reg != 4'h8) begin
                  sb_shift_reg <= {sb_shift_reg[6:0], sda};
                  sb_bits_reg  <= sb_bits_reg + 4'h1;
               end else if (byte_done) begin
                  if (ack_now) begin
                     sb_oe_reg    <= 1'b1;
                     sb_state_reg <= temp_monitor_pkg::SB_ACK;
                     if (sb_byte_reg == 2'h0)
                        sb_read_reg <= sb_shift_reg[0];
                  end else begin
                     sb_state_reg <= temp_monitor_pkg::SB_IDLE;
                  end
               end
            end
            temp_monitor_pkg::SB_ACK: begin
               if (scl_fall) begin
                  sb_bits_reg <= 4'h0;
                  if (sb_read_reg) begin
                     sb_shift_reg <= rd_byte;
                     sb_oe_reg    <= ~rd_byte[7];
                     sb_state_reg <= temp_monitor_pkg::SB_TX;
                  end else begin
                     sb_oe_reg    <= 1'b0;
                     sb_byte_reg  <= sb_byte_reg + 2'h1;
                     sb_state_reg <= temp_monitor_pkg::SB_RX;
                  end
               end
            end
            temp_monitor_pkg::SB_TX: begin
               if (scl_fall) begin
                  sb_bits_reg <= sb_bits_reg + 4'h1;
                  if (sb_bits_reg == 4'h7) begin
                     sb_oe_reg    <= 1'b0;
                     sb_state_reg <= temp_monitor_pkg::SB_TX_ACK;
                  end else begin
                     sb_shift_reg <= {sb_shift_reg[6:0], 1'b0};
                     sb_oe_reg    <= ~sb_shift_reg[6];
                  end
               end
            end
            temp_monitor_pkg::SB_TX_ACK: begin
               // Host acknowledge or not, one byte ends the read
               if (scl_rise)
                  sb_state_reg <= temp_monitor_pkg::SB_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         pointer_reg <= 8'h00;
      else if (ptr_load)
         pointer_reg <= sb_shift_reg;
   end

   // Open-drain data only; no clock output exists at all
   assign serial_bus_data_pin_out    = 1'b0;
   assign serial_bus_data_pin_oe_out = sb_oe_reg;

   // AXI4-Lite slave
   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic [7:0]  aw_addr_reg;
   logic [7:0]  w_data_reg;
   logic        w_lane_reg;
   logic        arready_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;
   logic [7:0]  link_byte;

   wire wr_do   = ~awready_reg & ~wready_reg & ~bvalid_reg;
   wire wr_ctl  = aw_addr_reg == temp_monitor_pkg::OFS_CONTROL;
   wire wr_os   = aw_addr_reg == temp_monitor_pkg::OFS_ONESHOT;
   wire axi_ctl_wr = wr_do & wr_ctl & w_lane_reg;
   wire axi_os_wr  = wr_do & wr_os & w_lane_reg;
   wire [7:0] ra   = s_axi_araddr_in;
   wire rd_hit  = (ra == temp_monitor_pkg::OFS_CONTROL) | (ra == temp_monitor_pkg::OFS_ONESHOT) |
                  (ra == temp_monitor_pkg::OFS_STATUS) | (ra == temp_monitor_pkg::OFS_ZONE0) |
                  (ra == temp_monitor_pkg::OFS_ZONE1) | (ra == temp_monitor_pkg::OFS_ZONE2) |
                  (ra == temp_monitor_pkg::OFS_LINK);
   wire [RW-1:0] ra_zone = (ra == temp_monitor_pkg::OFS_ZONE0) ? res_reg[0] :
                           (ra == temp_monitor_pkg::OFS_ZONE1) ? res_reg[1] : res_reg[2];
   wire [31:0] rd_word =
      (ra == temp_monitor_pkg::OFS_CONTROL) ? {24'h00_0000, ctl_reg} :
      (ra == temp_monitor_pkg::OFS_STATUS)  ? {24'h00_0000, status} :
      (ra == temp_monitor_pkg::OFS_LINK)    ? {16'h0000, link_byte, pointer_reg} :
      (ra == temp_monitor_pkg::OFS_ZONE0 || ra == temp_monitor_pkg::OFS_ZONE1 ||
       ra == temp_monitor_pkg::OFS_ZONE2)   ? {21'h00_0000, ra_zone} : 32'h0000_0000;

   assign link_byte = {5'h00, sb_state_reg};

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= temp_monitor_pkg::RESP_OKAY;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 8'h00;
         w_lane_reg  <= 1'b0;
      end else begin
         if (s_axi_awvalid_in && awready_reg) begin
            awready_reg <= 1'b0;
            aw_addr_reg <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && wready_reg) begin
            wready_reg <= 1'b0;
            w_data_reg <= s_axi_wdata_in[7:0];
            w_lane_reg <= s_axi_wstrb_in[0];
         end
         if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_ctl || wr_os) ? temp_monitor_pkg::RESP_OKAY : temp_monitor_pkg::RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready_in) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= temp_monitor_pkg::RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end else if (s_axi_arvalid_in && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_word;
         rresp_reg   <= rd_hit ? temp_monitor_pkg::RESP_OKAY : temp_monitor_pkg::RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready_in) begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   assign s_axi_awready_out = awready_reg;
   assign s_axi_wready_out  = wready_reg;
   assign s_axi_bvalid_out  = bvalid_reg;
   assign s_axi_bresp_out   = bresp_reg;
   assign s_axi_arready_out = arready_reg;
   assign s_axi_rvalid_out  = rvalid_reg;
   assign s_axi_rresp_out   = rresp_reg;
   assign s_axi_rdata_out   = rdata_reg;

   // Control: the bus slave wins a same-cycle collision with AXI
   wire [7:0] ctl_next = smb_ctl_wr ? sb_shift_reg : axi_ctl_wr ? w_data_reg : ctl_reg;
   wire       standby  = ctl_reg[temp_monitor_pkg::CTL_STANDBY];
   wire       warmer   = ctl_reg[temp_monitor_pkg::CTL_WARMER];
   wire       max_resolution_select = ctl_reg[temp_monitor_pkg::CTL_MAXRES];
   wire       averaging_disable     = ctl_reg[temp_monitor_pkg::CTL_AVGDIS];
   wire [2:0] rate_raw = ctl_reg[temp_monitor_pkg::CTL_RATE_MSB:temp_monitor_pkg::CTL_RATE_LSB];
   wire [2:0] rate_eff = (rate_raw > temp_monitor_pkg::RATE_MAX) ? temp_monitor_pkg::RATE_MAX : rate_raw;
   wire [1:0] avg_sel  =
      (averaging_disable || rate_eff > temp_monitor_pkg::RATE_2X_MAX) ? temp_monitor_pkg::AVG_1X :
      (max_resolution_select && rate_eff <= temp_monitor_pkg::RATE_4X_MAX) ? temp_monitor_pkg::AVG_4X :
      temp_monitor_pkg::AVG_2X;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         ctl_reg <= temp_monitor_pkg::CONTROL_RESET;
      else
         ctl_reg <= ctl_next;
   end

   // Conversion sequencer
   temp_monitor_pkg::seq_t seq_state_reg;
   logic [1:0]    chan_reg;
   logic          os_run_reg;
   logic          adc_start_reg;
   logic [1:0]    adc_avg_reg;
   logic          low_power_reg;
   logic [RW-1:0] z2_raw_reg;
   logic [PW-1:0] per_cnt_reg;

   wire [PW-1:0] per_len = PW'(SET_PERIOD_CYCLES) >> rate_eff;
   wire          tick    = (per_cnt_reg == '0);
   wire          os_set  = (smb_os_wr | axi_os_wr) & standby;
   wire          os_take = (seq_state_reg == temp_monitor_pkg::SQ_SLEEP) & os_pend_reg;
   wire          cmp_gt  = $signed(res_reg[1]) > $signed(z2_raw_reg);
   wire          last_ch = (chan_reg == 2'h2);
   wire          set_end = (seq_state_reg == temp_monitor_pkg::SQ_COMPARE) |
                           ((seq_state_reg == temp_monitor_pkg::SQ_CONV) & adc_done_in & last_ch & ~warmer);
   wire          begin_set = os_take |
                             ((seq_state_reg == temp_monitor_pkg::SQ_WAIT) & ~standby & tick);
   wire          next_ch = (seq_state_reg == temp_monitor_pkg::SQ_CONV) & adc_done_in & ~last_ch;

   assign busy = (seq_state_reg == temp_monitor_pkg::SQ_CONV) |
                 (seq_state_reg == temp_monitor_pkg::SQ_COMPARE);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         os_pend_reg <= 1'b0;
         per_cnt_reg <= '0;
      end else begin
         os_pend_reg <= os_set | (os_pend_reg & ~os_take);
         per_cnt_reg <= tick ? per_len - PW'(1) : per_cnt_reg - PW'(1);
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         seq_state_reg <= temp_monitor_pkg::SQ_SLEEP;
         chan_reg      <= 2'h0;
         os_run_reg    <= 1'b0;
         adc_start_reg <= 1'b0;
         adc_avg_reg   <= temp_monitor_pkg::AVG_1X;
         low_power_reg <= 1'b1;
      end else begin
         adc_start_reg <= begin_set | next_ch;
         low_power_reg <= ~busy;
         if (begin_set) begin
            chan_reg      <= 2'h0;
            adc_avg_reg   <= temp_monitor_pkg::AVG_1X;
            os_run_reg    <= os_take;
            seq_state_reg <= temp_monitor_pkg::SQ_CONV;
         end else if (next_ch) begin
            chan_reg    <= chan_reg + 2'h1;
            adc_avg_reg <= avg_sel;
         end else if (set_end) begin
            seq_state_reg <= (os_run_reg || standby) ? temp_monitor_pkg::SQ_SLEEP : temp_monitor_pkg::SQ_WAIT;
            os_run_reg    <= 1'b0;
         end else if (seq_state_reg == temp_monitor_pkg::SQ_CONV && adc_done_in) begin
            seq_state_reg <= temp_monitor_pkg::SQ_COMPARE;
         end else if (seq_state_reg == temp_monitor_pkg::SQ_SLEEP && !standby) begin
            seq_state_reg <= temp_monitor_pkg::SQ_WAIT;
         end else if (seq_state_reg == temp_monitor_pkg::SQ_WAIT && standby) begin
            seq_state_reg <= temp_monitor_pkg::SQ_SLEEP;
         end
      end
   end

   // Results and the warmer-zone flag
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         res_reg[0] <= '0;
         res_reg[1] <= '0;
         res_reg[2] <= '0;
         z2_raw_reg <= '0;
         hotter_reg <= 1'b0;
      end else if (seq_state_reg == temp_monitor_pkg::SQ_CONV && adc_done_in) begin
         if (last_ch && warmer)
            z2_raw_reg <= adc_result_in;
         else
            res_reg[chan_reg] <= adc_result_in;
      end else if (seq_state_reg == temp_monitor_pkg::SQ_COMPARE) begin
         res_reg[2] <= cmp_gt ? res_reg[1] : z2_raw_reg;
         hotter_reg <= cmp_gt;
      end
   end

   assign adc_start_out   = adc_start_reg;
   assign adc_channel_out = chan_reg;
   assign adc_average_out = adc_avg_reg;
   assign low_power_out   = low_power_reg;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_addr_nack: assert property (byte_done && sb_byte_reg == 2'h0 && !addr_hit |=>
      sb_state_reg == temp_monitor_pkg::SB_IDLE && !sb_oe_reg) else $error("bad address was acknowledged");
   a_addr_ack: assert property (byte_done && sb_byte_reg == 2'h0 && addr_hit && !stop_det |=>
      sb_oe_reg && sb_state_reg == temp_monitor_pkg::SB_ACK) else $error("own address not acknowledged");
   a_send_pointer: assert property (ptr_load |-> !smb_ctl_wr && !smb_os_wr ##1
      pointer_reg == $past(sb_shift_reg)) else $error("command byte did not load only the pointer");
   a_pointer_stable: assert property (sb_state_reg == temp_monitor_pkg::SB_TX |=>
      $stable(pointer_reg)) else $error("pointer moved during a read");
   a_timeout_idle: assert property (to_hit && !start_det |=>
      sb_state_reg == temp_monitor_pkg::SB_IDLE && !sb_oe_reg) else $error("timeout did not reset slave");
   a_sleep_quiet: assert property (seq_state_reg == temp_monitor_pkg::SQ_SLEEP && !os_pend_reg |=>
      !adc_start_reg) else $error("conversion started in standby");
   a_oneshot_go: assert property (os_take |=> adc_start_reg && chan_reg == 2'h0 ##1
      os_run_reg) else $error("one-shot did not start a set");
   a_warm_copy: assert property (seq_state_reg == temp_monitor_pkg::SQ_COMPARE && cmp_gt |=>
      res_reg[2] == res_reg[1] && hotter_reg) else $error("hotter zone one not copied");
   a_warm_equal: assert property (seq_state_reg == temp_monitor_pkg::SQ_COMPARE &&
      res_reg[1] == z2_raw_reg |=> !hotter_reg && res_reg[2] == $past(z2_raw_reg))
      else $error("equal zones handled wrongly");
   a_avg_fast: assert property (next_ch && rate_eff == temp_monitor_pkg::RATE_MAX |=>
      adc_avg_reg == temp_monitor_pkg::AVG_1X) else $error("averaging used at top rate");
endmodule : temp_monitor_smbus_sequencer

// ---- smbus_host_model.sv ----
// Host side of the two-wire bus: a master that drives clock and data open drain.
// Assumes the bench resolves the data wire with a pull-up; 1 here releases a line.
module smbus_host_model (
   input  wire logic clk_in,
   input  wire logic wire_sda_in,
   output logic      scl_out,
   output logic      sda_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Clock stands high between frames; data moves mid low phase
   task automatic bit_cyc(input logic b, output logic s);
      repeat (2) @(posedge clk_in);
      sda_out <= b;
      repeat (2) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      s = wire_sda_in;
      scl_out <= 1'b0;
   endtask : bit_cyc
   task automatic start;
      repeat (2) @(posedge clk_in);
      sda_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sda_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      scl_out <= 1'b0;
   endtask : start
   task automatic stop;
      repeat (2) @(posedge clk_in);
      sda_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sda_out <= 1'b1;
      repeat (4) @(posedge clk_in);
   endtask : stop
   // MSB first; ninth bit released, so reads always end in not-acknowledge
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(tx[i], rx[i]);
      bit_cyc(1'b1, s);
      ack = ~s;
   endtask : xfer
endmodule : smbus_host_model

// ---- tb.sv ----
// Bench for the temperature monitor: bus host model, converter stub, AXI4-Lite master.
// Assumes the design's registered outputs, so answers are read at the falling edge before.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] ADDR = 7'h2A;
   logic clk_in, rst_in, adc_done_in, adc_start_out, low_power_out, scl, sda, s_axi_awvalid_in, s_axi_wvalid_in;
   logic s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out, serial_bus_data_pin_out, serial_bus_data_pin_oe_out;
   logic [10:0] adc_result_in;
   logic [1:0] adc_channel_out, adc_average_out, s_axi_bresp_out, s_axi_rresp_out, rs, avg_seen;
   logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, rxd;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdat;
   logic [3:0] s_axi_wstrb_in;
   int errors, n_compared, n_starts;
   wire serial_bus_clock_pin_in = scl;
   wire serial_bus_data_pin_in = sda & ~serial_bus_data_pin_oe_out;
   temp_monitor_smbus_sequencer #(.TIMEOUT_CYCLES(200), .SET_PERIOD_CYCLES(3200), .SLAVE_ADDR(ADDR)) dut (.*);
   smbus_host_model host (.clk_in(clk_in), .wire_sda_in(serial_bus_data_pin_in), .scl_out(scl), .sda_out(sda));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      adc_done_in <= adc_start_out;
      adc_result_in <= 11'h110 - 11'(adc_channel_out);
      if (adc_start_out) n_starts++;
      if (adc_start_out) avg_seen <= adc_average_out;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic tx(input logic [7:0] b, input logic ea);
      logic a;
      host.xfer(b, rxd, a);
      chk(a, ea);
   endtask : tx
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic ra, rw, rb;
      @(posedge clk_in);
      s_axi_awaddr_in <= a; s_axi_wdata_in <= d; s_axi_awvalid_in <= 1'b1; s_axi_wvalid_in <= 1'b1; s_axi_bready_in <= 1'b1;
      do begin
         @(negedge clk_in);
         ra = s_axi_awready_out; rw = s_axi_wready_out; rb = s_axi_bvalid_out; rs = s_axi_bresp_out;
         @(posedge clk_in);
         if (ra) s_axi_awvalid_in <= 1'b0;
         if (rw) s_axi_wvalid_in <= 1'b0;
      end while (!rb);
      s_axi_bready_in <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      logic ra, rb;
      @(posedge clk_in);
      s_axi_araddr_in <= a; s_axi_arvalid_in <= 1'b1; s_axi_rready_in <= 1'b1;
      do begin
         @(negedge clk_in);
         ra = s_axi_arready_out; rb = s_axi_rvalid_out; rdat = s_axi_rdata_out; rs = s_axi_rresp_out;
         @(posedge clk_in);
         if (ra) s_axi_arvalid_in <= 1'b0;
      end while (!rb);
      s_axi_rready_in <= 1'b0;
   endtask : axi_rd
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   initial begin
      #2000000;
      errors++;
      print_verdict;
   end
   initial begin
      rst_in = 1'b1; s_axi_awvalid_in = 1'b0; s_axi_wvalid_in = 1'b0;
      s_axi_bready_in = 1'b0; s_axi_arvalid_in = 1'b0; s_axi_rready_in = 1'b0; s_axi_awaddr_in = 8'h00;
      s_axi_araddr_in = 8'h00; s_axi_wdata_in = 32'h0000_0000; s_axi_wstrb_in = 4'hF;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      t_rst;
      t_bus;
      t_ptr;
      t_os;
      t_warm;
      print_verdict;
   end
   task automatic t_rst;
      @(negedge clk_in);
      chk(low_power_out, 1'b1);
      axi_rd(temp_monitor_pkg::OFS_CONTROL);
      chk(rdat[7:0], temp_monitor_pkg::CONTROL_RESET);
      $display("test reset done");
   endtask : t_rst
   task automatic t_bus;
      host.start; tx({ADDR, 1'b0}, 1); tx(8'h00, 1); tx(8'h29, 1); host.stop;
      axi_rd(temp_monitor_pkg::OFS_CONTROL);
      chk(rdat[7:0], 8'h29);
      host.start; tx({ADDR, 1'b0}, 1); tx(8'h00, 1); host.start; tx({ADDR, 1'b1}, 1); tx(8'hFF, 0); host.stop;
      chk(rxd, 8'h29);
      host.start; tx({ADDR, 1'b1}, 1); tx(8'hFF, 0); host.stop;
      chk(rxd, 8'h29);
      $display("test bus access done");
   endtask : t_bus
   task automatic t_ptr;
      host.start; tx({7'h2B, 1'b0}, 0); host.stop;
      host.start; tx({ADDR, 1'b0}, 1); tx(8'h02, 1); host.stop;
      axi_rd(temp_monitor_pkg::OFS_LINK);
      chk(rdat[7:0], 8'h02);
      axi_rd(temp_monitor_pkg::OFS_CONTROL);
      chk(rdat[7:0], 8'h29);
      $display("test pointer done");
   endtask : t_ptr
   task automatic t_os;
      n_starts = 0;
      axi_wr(temp_monitor_pkg::OFS_ONESHOT, 32'h0000_0001);
      chk(rs, temp_monitor_pkg::RESP_OKAY);
      for (int i = 0; i < 400 && !(low_power_out && n_starts == 3); i++) @(negedge clk_in);
      chk(n_starts, 3);
      chk(low_power_out, 1'b1);
      axi_rd(8'h1C);
      chk(rs, temp_monitor_pkg::RESP_SLVERR);
      $display("test one-shot done");
   endtask : t_os
   task automatic t_warm;
      axi_wr(temp_monitor_pkg::OFS_CONTROL, 32'h0000_0017);
      axi_wr(temp_monitor_pkg::OFS_ONESHOT, 32'h0000_0001);
      repeat (250) @(negedge clk_in);
      chk(avg_seen, temp_monitor_pkg::AVG_4X);
      axi_rd(temp_monitor_pkg::OFS_STATUS);
      chk(rdat[0], 1'b1);
      axi_rd(temp_monitor_pkg::OFS_ZONE2);
      chk(rdat, 32'h0000_010F);
      $display("test warmer done");
   endtask : t_warm
endmodule : tb
